//--- rgn_pkg.sv
package rgn_pkg;

   // Nibble positions within a byte
   localparam int LO_NIB_MSB = 3;
   localparam int LO_NIB_LSB = 0;
   localparam int HI_NIB_MSB = 7;
   localparam int HI_NIB_LSB = 4;

   localparam logic [3:0] NIB_IDLE  = 4'h0;
   localparam logic [7:0] BYTE_IDLE = 8'h00;

   // Transmit quarter phases, one core cycle each
   typedef enum logic [1:0] {
      RGN_TXP_LO_A = 2'b00,
      RGN_TXP_LO_B = 2'b01,
      RGN_TXP_HI_A = 2'b10,
      RGN_TXP_HI_B = 2'b11
   } rgn_tx_phase_t;

   // Byte offered for transmission
   typedef struct packed {
      logic [7:0] data;
      logic       err;
   } rgn_tx_byte_t;

   // Byte recovered from the receive pins
   typedef struct packed {
      logic [7:0] data;
      logic       dv;
      logic       er;
   } rgn_rx_byte_t;

endpackage : rgn_pkg

//--- rgn_rgmii_nibble.sv
// Notes on behaviour
// - The transmit clock leaves the block delayed a quarter period so its edges sit mid data eye, always.
// - Transmit bits 3-0 of a byte are on the bus at the clock rising edge and bits 7-4 at the next falling edge.
// - The transmit control line carries enable at the rising edge and error at the falling edge.
// - Received bits 3-0 are taken at the receive clock rising edge and bits 7-4 at the next falling edge.
// - The receive control line is sampled as data valid at the rising edge and as error at the falling edge.
module rgn_rgmii_nibble (
   // Core clock and reset
   input  wire logic                  core_clk,
   input  wire logic                  arst_n,
   // Transmit user side, core domain
   input  wire logic                  tx_valid,
   input  wire rgn_pkg::rgn_tx_byte_t tx_byte,
   output logic                       tx_ready,
   // Transmit pins
   output logic                       main_subsystem_tx_clock,
   output logic [3:0]                 tx_nibble_bus,
   output logic                       tx_ctl_pin,
   // Receive pins, source synchronous to rx_link_clk
   input  wire logic                  rx_link_clk,
   input  wire logic [3:0]            gig_rx_nibble_bus,
   input  wire logic                  rx_ctl_pin,
   // Receive user side, link domain
   output rgn_pkg::rgn_rx_byte_t      rx_byte,
   // Receive frame activity, core domain
   output logic                       rx_active
);

   // ---------------- Transmit, core domain ----------------
   rgn_pkg::rgn_tx_phase_t phase;
   rgn_pkg::rgn_tx_phase_t next_phase;
   logic [7:0]             cur_data;
   logic [7:0]             next_cur_data;
   logic                   cur_en;
   logic                   next_cur_en;
   logic                   cur_err;
   logic                   next_cur_err;
   logic                   next_txc;
   logic [3:0]             next_txd;
   logic                   next_txctl;

   // Next byte is taken in the last quarter so it starts on a clean boundary
   assign tx_ready = (phase == rgn_pkg::RGN_TXP_HI_B);

   always_comb begin
      next_phase    = rgn_pkg::rgn_tx_phase_t'(phase + 2'b01);
      next_cur_data = cur_data;
      next_cur_en   = cur_en;
      next_cur_err  = cur_err;
      next_txd      = tx_nibble_bus;
      next_txctl    = tx_ctl_pin;
      // Clock high during quarters LO_B and HI_A: a quarter period behind data
      next_txc      = (phase == rgn_pkg::RGN_TXP_LO_A) || (phase == rgn_pkg::RGN_TXP_LO_B);
      case (phase)
         rgn_pkg::RGN_TXP_HI_B: begin
            if (tx_valid) begin
               next_cur_data = tx_byte.data;
               next_cur_en   = 1'b1;
               next_cur_err  = tx_byte.err;
            end else begin
               next_cur_data = rgn_pkg::BYTE_IDLE;
               next_cur_en   = 1'b0;
               next_cur_err  = 1'b0;
            end
            next_txd   = next_cur_data[rgn_pkg::LO_NIB_MSB:rgn_pkg::LO_NIB_LSB];
            next_txctl = next_cur_en;
         end
         rgn_pkg::RGN_TXP_LO_B: begin
            next_txd   = cur_data[rgn_pkg::HI_NIB_MSB:rgn_pkg::HI_NIB_LSB];
            next_txctl = cur_err;
         end
         default: begin
         end
      endcase
   end

   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         phase                   <= rgn_pkg::RGN_TXP_LO_A;
         cur_data                <= rgn_pkg::BYTE_IDLE;
         cur_en                  <= 1'b0;
         cur_err                 <= 1'b0;
         main_subsystem_tx_clock <= 1'b0;
         tx_nibble_bus           <= rgn_pkg::NIB_IDLE;
         tx_ctl_pin              <= 1'b0;
      end else begin
         phase                   <= next_phase;
         cur_data                <= next_cur_data;
         cur_en                  <= next_cur_en;
         cur_err                 <= next_cur_err;
         main_subsystem_tx_clock <= next_txc;
         tx_nibble_bus           <= next_txd;
         tx_ctl_pin              <= next_txctl;
      end
   end

   tx_edge_mid_eye_a: assert property (@(posedge core_clk) disable iff (!arst_n)
      $changed(main_subsystem_tx_clock) |-> $stable(tx_nibble_bus) && $stable(tx_ctl_pin)
         ##1 $stable(main_subsystem_tx_clock))
      else $error("tx data moved next to a tx clock edge");

   tx_nibble_order_a: assert property (@(posedge core_clk) disable iff (!arst_n)
      $rose(main_subsystem_tx_clock) |-> tx_nibble_bus == cur_data[rgn_pkg::LO_NIB_MSB:rgn_pkg::LO_NIB_LSB]
         ##2 $fell(main_subsystem_tx_clock)
         && tx_nibble_bus == $past(cur_data[rgn_pkg::HI_NIB_MSB:rgn_pkg::HI_NIB_LSB], 2))
      else $error("tx nibble order wrong");

   tx_ctl_phases_a: assert property (@(posedge core_clk) disable iff (!arst_n)
      $rose(main_subsystem_tx_clock) |-> tx_ctl_pin == cur_en ##2 tx_ctl_pin == $past(cur_err, 2))
      else $error("tx control phase wrong");

   tx_accept_a: assert property (@(posedge core_clk) disable iff (!arst_n)
      tx_ready && tx_valid |=> cur_en && cur_data == $past(tx_byte.data) ##1 main_subsystem_tx_clock)
      else $error("tx byte not launched");

   // Pin checks: clock shape, ready slot, idle slot and launch of the accepted byte
   tx_clock_shape_a: assert property (@(posedge core_clk) disable iff (!arst_n)
      $rose(main_subsystem_tx_clock) |=>
         main_subsystem_tx_clock ##1 !main_subsystem_tx_clock ##1 !main_subsystem_tx_clock ##1 main_subsystem_tx_clock)
      else $error("tx clock shape wrong");

   tx_ready_slot_a: assert property (@(posedge core_clk) disable iff (!arst_n)
      tx_ready |->
         !main_subsystem_tx_clock && $past(main_subsystem_tx_clock))
      else $error("tx ready outside its slot");

   tx_idle_gap_a: assert property (@(posedge core_clk) disable iff (!arst_n)
      tx_ready && !tx_valid |=>
         !tx_ctl_pin && tx_nibble_bus == rgn_pkg::NIB_IDLE)
      else $error("tx idle slot not idle");

   tx_lo_launch_a: assert property (@(posedge core_clk) disable iff (!arst_n)
      tx_ready && tx_valid |=>
         tx_ctl_pin && tx_nibble_bus == $past(tx_byte.data[rgn_pkg::LO_NIB_MSB:rgn_pkg::LO_NIB_LSB]))
      else $error("tx low nibble not launched");

   tx_hi_launch_a: assert property (@(posedge core_clk) disable iff (!arst_n)
      tx_ready && tx_valid |=>
         ##2 tx_nibble_bus == $past(tx_byte.data[rgn_pkg::HI_NIB_MSB:rgn_pkg::HI_NIB_LSB], 3))
      else $error("tx high nibble not launched");

   tx_err_launch_a: assert property (@(posedge core_clk) disable iff (!arst_n)
      tx_ready && tx_valid |=>
         ##2 tx_ctl_pin == $past(tx_byte.err, 3))
      else $error("tx error phase not launched");

   tx_en_hold_a: assert property (@(posedge core_clk) disable iff (!arst_n)
      tx_ready && tx_valid |=>
         tx_ctl_pin ##1 tx_ctl_pin)
      else $error("tx enable phase too short");

   // ---------------- Receive, link domain ----------------
   // the capture flops sample the pins directly; any skew is the board's
   logic       rx_rst_meta;
   logic       rx_rst_n;
   logic [3:0] rx_lo;
   logic       rx_dv;
   logic [3:0] rx_hi;
   logic       rx_er;
   rgn_pkg::rgn_rx_byte_t next_rx_byte;

   // Reset release retimed to the link clock
   always_ff @(posedge rx_link_clk or negedge arst_n) begin
      if (!arst_n) begin
         rx_rst_meta <= 1'b0;
         rx_rst_n    <= 1'b0;
      end else begin
         rx_rst_meta <= 1'b1;
         rx_rst_n    <= rx_rst_meta;
      end
   end

   always_comb begin
      next_rx_byte.data = {rx_hi, rx_lo};
      next_rx_byte.dv   = rx_dv;
      next_rx_byte.er   = rx_er;
   end

   always_ff @(posedge rx_link_clk or negedge rx_rst_n) begin
      if (!rx_rst_n) begin
         rx_lo   <= rgn_pkg::NIB_IDLE;
         rx_dv   <= 1'b0;
         rx_byte <= '0;
      end else begin
         rx_lo   <= gig_rx_nibble_bus;
         rx_dv   <= rx_ctl_pin;
         rx_byte <= next_rx_byte;
      end
   end

   always_ff @(negedge rx_link_clk or negedge rx_rst_n) begin
      if (!rx_rst_n) begin
         rx_hi <= rgn_pkg::NIB_IDLE;
         rx_er <= 1'b0;
      end else begin
         rx_hi <= gig_rx_nibble_bus;
         rx_er <= rx_ctl_pin;
      end
   end

   rx_byte_assembly_a: assert property (@(posedge rx_link_clk) disable iff (!rx_rst_n)
      ##1 rx_byte.data == {$past(rx_hi), $past(rx_lo)})
      else $error("rx byte not built from captured nibbles");

   rx_ctl_phases_a: assert property (@(posedge rx_link_clk) disable iff (!rx_rst_n)
      ##1 rx_byte.dv == $past(rx_dv) && rx_byte.er == $past(rx_er))
      else $error("rx control phases wrong");

   // ---------------- Frame activity into core domain ----------------
   logic act_meta;
   logic next_rx_active;

   assign next_rx_active = act_meta;

   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         act_meta  <= 1'b0;
         rx_active <= 1'b0;
      end else begin
         act_meta  <= rx_byte.dv;
         rx_active <= next_rx_active;
      end
   end

endmodule // rgn_rgmii_nibble

//--- rgn_phy_model.sv
module rgn_phy_model (
   // Receive pins toward the block
   input  wire logic                  run,
   input  wire rgn_pkg::rgn_rx_byte_t src,
   output logic                       rx_clk,
   output logic [3:0]                 rx_nib,
   output logic                       rx_ctl,
   // Transmit pins from the block
   input  wire logic                  tx_clk,
   input  wire logic [3:0]            tx_nib,
   input  wire logic                  tx_ctl,
   output rgn_pkg::rgn_tx_byte_t      got,
   output logic                       got_en,
   output logic                       setup_ok
);
   timeunit 1ns;
   timeprecision 1ns;
   rgn_pkg::rgn_rx_byte_t sent_q[$];
   rgn_pkg::rgn_rx_byte_t cur;
   realtime               t_chg;
   initial begin
      rx_clk = 1'b0;
      rx_nib = 4'h0;
      rx_ctl = 1'b0;
      t_chg  = 0;
      forever begin
         if (!run) begin
            // Clock stands still; lines churn
            rx_nib = ~rx_nib;
            rx_ctl = ~rx_ctl;
            #40;
            continue;
         end
         cur    = src;
         rx_nib = cur.data[3:0];
         rx_ctl = cur.dv;
         #40 rx_clk = 1'b1;
         #40 rx_nib = cur.data[7:4];
         rx_ctl = cur.er;
         #40 rx_clk = 1'b0;
         sent_q.push_back(cur);
         #40;
      end
   end
   always @(tx_nib or tx_ctl) t_chg = $realtime;
   always @(posedge tx_clk) begin
      got.data[3:0] <= tx_nib;
      got_en        <= tx_ctl;
      setup_ok      <= ($realtime - t_chg) >= 1.2;
   end
   always @(negedge tx_clk) begin
      got.data[7:4] <= tx_nib;
      got.err       <= tx_ctl;
      setup_ok      <= setup_ok && (($realtime - t_chg) >= 1.2);
   end
endmodule // rgn_phy_model

//--- rgn_rgmii_nibble_tb.sv
module rgn_rgmii_nibble_tb;
   timeunit 1ns;
   timeprecision 1ns;
`define CHK(nm, e, s) begin compares++; if ((e) !== (s)) begin n_fail++; \
   $display("ERROR %s expected %h seen %h", nm, e, s); end end
   logic                  core_clk, arst_n, tx_valid, tx_ready, run, rx_clk, tx_clk, rx_ctl;
   logic                  tx_ctl, got_en, setup_ok, rx_active;
   logic [3:0]            rx_nib, tx_nib;
   rgn_pkg::rgn_tx_byte_t tx_byte, got, tx_exp;
   rgn_pkg::rgn_rx_byte_t src, rx_byte, rx_exp;
   rgn_pkg::rgn_tx_byte_t tx_q[$];
   int                    n_fail, compares, rises;
   initial begin
      core_clk = 1'b0;
      forever #50 core_clk = ~core_clk;
   end
   rgn_rgmii_nibble DUT (.core_clk(core_clk), .arst_n(arst_n), .tx_valid(tx_valid), .tx_byte(tx_byte),
      .tx_ready(tx_ready), .main_subsystem_tx_clock(tx_clk), .tx_nibble_bus(tx_nib), .tx_ctl_pin(tx_ctl),
      .rx_link_clk(rx_clk), .gig_rx_nibble_bus(rx_nib), .rx_ctl_pin(rx_ctl), .rx_byte(rx_byte),
      .rx_active(rx_active));
   rgn_phy_model phy (.run(run), .src(src), .rx_clk(rx_clk), .rx_nib(rx_nib), .rx_ctl(rx_ctl),
      .tx_clk(tx_clk), .tx_nib(tx_nib), .tx_ctl(tx_ctl), .got(got), .got_en(got_en), .setup_ok(setup_ok));
   task print_verdict;
      $display("compares %0d n_fail %0d", compares, n_fail);
      if (n_fail == 0 && compares > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   initial begin
      arst_n   = 1'b0;
      tx_valid = 1'b0;
      tx_byte  = '0;
      run      = 1'b0;
      src      = '0;
      n_fail   = 0;
      compares = 0;
      rises    = 0;
      void'($urandom(2));
      repeat (6) @(posedge core_clk);
      `CHK("rx_active_rst", 1'b0, rx_active)
      arst_n   <= 1'b1;
      run      <= 1'b1;
      tx_valid <= 1'b1;
      tx_byte  <= 9'($urandom);
      repeat (40) begin
         @(posedge core_clk);
         while (tx_ready !== 1'b1) @(posedge core_clk);
         if (tx_valid) tx_q.push_back(tx_byte);
         tx_byte  <= 9'($urandom);
         src      <= 10'($urandom);
         tx_valid <= ($urandom % 4) != 0;
      end
      tx_valid <= 1'b0;
      src      <= 10'h3FF;
      repeat (80) @(posedge core_clk);
      `CHK("tx_left", 0, tx_q.size())
      `CHK("rx_active", 1'b1, rx_active)
      print_verdict;
   end
   always @(negedge tx_clk) begin
      #1;
      if (got_en === 1'b1) begin
         tx_exp = tx_q.pop_front();
         `CHK("tx_byte", tx_exp, got)
         `CHK("tx_setup", 1'b1, setup_ok)
      end
   end
   always @(posedge rx_clk) begin
      #1;
      rises++;
      if (phy.sent_q.size() > 0) begin
         rx_exp = phy.sent_q.pop_front();
         if (rises >= 5) `CHK("rx_byte", rx_exp, rx_byte)
      end
   end
   initial begin
      #100000;
      n_fail++;
      print_verdict;
   end
endmodule // rgn_rgmii_nibble_tb
